//--- hw/dsr_pkg.sv
// constants, register map and reset values for the demodulator status readout bank
package dsr_pkg;

	// register byte offsets on the apb word grid
	localparam logic [7:0] OFS_PREAMBLE_SYNC_QUALITY = 8'h00;
	localparam logic [7:0] OFS_DEMODULATOR_FLAGS     = 8'h04;
	localparam logic [7:0] OFS_CARRIER_OFFSET_HIGH   = 8'h08;
	localparam logic [7:0] OFS_CARRIER_OFFSET_LOW    = 8'h0c;
	localparam logic [7:0] OFS_APPLIED_GAIN_STATUS   = 8'h10;
	localparam logic [7:0] OFS_RX_CONTEXT_STATUS     = 8'h14;

	// preamble_sync_quality fields
	localparam int PQ_PREAMBLE_LSB = 4;
	localparam int PQ_SYNC_LSB     = 0;
	localparam int QUAL_FIELD_W    = 4;
	localparam int SYNC_QUAL_SHIFT = 1;
	localparam int PRE_QUAL_SHIFT  = 0;

	// demodulator_flags fields
	localparam int DF_LEVEL_JUMP  = 7;
	localparam int DF_SECOND_SYNC = 6;
	localparam int DF_DUAL_SYNC   = 5;
	localparam int DF_SRO_LSB     = 1;
	localparam int DF_MIRROR      = 0;
	localparam int SRO_W          = 4;

	// carrier offset and gain
	localparam int CFO_W       = 16;
	localparam int CFO_HIGH_LSB = 8;
	localparam int GAIN_W      = 7;

	// rx_context_status fields
	localparam int CTX_SEARCHING   = 0;
	localparam int CTX_IN_PACKET   = 1;
	localparam int CTX_TOL_LSB     = 2;
	localparam int CTX_SYNC_MODE_LSB = 4;
	localparam int CTX_COLL_EN     = 7;

	// reset values
	localparam logic [3:0]  RST_QUAL_FIELD = 4'hf;
	localparam logic [7:0]  RST_FLAGS      = 8'h00;
	localparam logic [15:0] RST_CFO        = 16'h0000;
	localparam logic [6:0]  RST_GAIN       = 7'h00;

	// sync mode that enables dual sync word search
	localparam logic [2:0] SYNC_MODE_DUAL = 3'h7;

	// level jump step sizes in decibels
	localparam logic [8:0] STEP_SMALL_DB = 9'h003;
	localparam logic [8:0] STEP_LARGE_DB = 9'h006;

	// receive phase
	typedef enum logic [1:0] {
		DSR_IDLE      = 2'b00,
		DSR_SEARCHING = 2'b01,
		DSR_IN_PACKET = 2'b10
	} dsr_phase_e;

endpackage : dsr_pkg

//--- hw/dsr_qual_hold.sv
// qualifier count field that follows the raw count while searching and freezes at sync
`timescale 1ns/100ps
module dsr_qual_hold #(
	parameter int              RAW_W   = 8,
	parameter int              SHIFT   = 0,
	parameter logic [3:0]      RST_VAL = 4'hf
) (
	input  wire logic             mclk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             refresh_i,
	input  wire logic [RAW_W-1:0] raw_count_i,
	output logic      [3:0]       field_o
);

	generate
		if (RAW_W < SHIFT + 4) begin : g_bad_width
			$error("dsr_qual_hold: raw count too narrow for the field");
		end
	endgenerate

	logic [3:0] field_q;
	logic [3:0] field_d;
	wire  [3:0] folded = raw_count_i[SHIFT +: 4];

	// taking the low bits after the shift is divide-then-modulo-16 in one step
	assign field_d = refresh_i ? folded : field_q;

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			field_q <= RST_VAL;
		end else begin
			field_q <= field_d;
		end
	end

	assign field_o = field_q;

endmodule : dsr_qual_hold

//--- hw/dsr_status_bank.sv
// read-only demodulator status register bank behind an apb slave
//
// Contract
// - preamble qualifier field in bits 7:4 is the count modulo 16.
// - qualifier fields track while searching, freeze after sync until receive re-entry.
// - sync qualifier field in bits 3:0 is count halved, floored, modulo 16.
// - bit 7 flags a signal level step past threshold during packet reception.
// - with collision watch on, bit 6 flags a further sync during packet.
// - in dual sync mode bit 5 tells which sync word matched at sync.
// - bits 4:1 carry the signed symbol rate offset indicator, may wrap.
// - carrier offset estimate is 16-bit signed, split high and low bytes.
// - gain register bits 6:0 show applied front-end gain, bit 7 zero.
`timescale 1ns/100ps
module dsr_status_bank #(
	parameter int ADDR_W = 8,
	parameter int RAW_W  = 8
) (
	input  wire logic              mclk_i,
	input  wire logic              sys_rst_i,
	// apb slave
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [31:0]       pwdata_i,
	input  wire logic [3:0]        pstrb_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// receive sequencing
	input  wire logic              rx_enter_i,
	input  wire logic              rx_leave_i,
	input  wire logic              sync_found_i,
	// qualifier counts
	input  wire logic [RAW_W-1:0]  preamble_qual_raw_i,
	input  wire logic [RAW_W-1:0]  sync_qual_raw_i,
	// signal level
	input  wire logic [7:0]        rssi_db_i,
	input  wire logic              rssi_valid_i,
	input  wire logic              level_jump_threshold_i,
	// sync detection and configuration
	input  wire logic              sync_detect_i,
	input  wire logic              collision_watch_enable_i,
	input  wire logic [2:0]        sync_word_mode_i,
	input  wire logic              upper_sync_match_i,
	// symbol rate offset
	input  wire logic [3:0]        symbol_rate_offset_ind_i,
	input  wire logic              sro_valid_i,
	input  wire logic [1:0]        timing_offset_limit_i,
	// carrier offset and gain
	input  wire logic [15:0]       carrier_offset_estimate_i,
	input  wire logic              cfo_valid_i,
	input  wire logic [6:0]        applied_frontend_gain_i,
	input  wire logic              image_detect_i
);

	generate
		// the word decode reads address bits 7:2, so a narrower bus cannot be served
		if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
			$error("dsr_status_bank: ADDR_W must be 8 to 32");
		end
		if (RAW_W < 5) begin : g_bad_raw
			$error("dsr_status_bank: RAW_W must be at least 5");
		end
	endgenerate

	// ------------------------------------------------------------------
	// receive phase
	// ------------------------------------------------------------------
	dsr_pkg::dsr_phase_e phase_q;
	dsr_pkg::dsr_phase_e phase_d;

	// a fresh receive entry outranks a sync in the same cycle: the search restarts
	always_comb begin
		phase_d = phase_q;
		case (phase_q)
			dsr_pkg::DSR_IDLE: begin
				if (rx_enter_i) begin
					phase_d = dsr_pkg::DSR_SEARCHING;
				end
			end
			dsr_pkg::DSR_SEARCHING: begin
				if (rx_enter_i) begin
					phase_d = dsr_pkg::DSR_SEARCHING;
				end else if (rx_leave_i) begin
					phase_d = dsr_pkg::DSR_IDLE;
				end else if (sync_found_i) begin
					phase_d = dsr_pkg::DSR_IN_PACKET;
				end
			end
			dsr_pkg::DSR_IN_PACKET: begin
				if (rx_enter_i) begin
					phase_d = dsr_pkg::DSR_SEARCHING;
				end else if (rx_leave_i) begin
					phase_d = dsr_pkg::DSR_IDLE;
				end
			end
			default: begin
				phase_d = dsr_pkg::DSR_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			phase_q <= dsr_pkg::DSR_IDLE;
		end else begin
			phase_q <= phase_d;
		end
	end

	wire searching = (phase_q == dsr_pkg::DSR_SEARCHING);
	wire in_packet = (phase_q == dsr_pkg::DSR_IN_PACKET);
	wire sync_hit  = searching & sync_found_i & ~rx_enter_i & ~rx_leave_i;

	// ------------------------------------------------------------------
	// qualifier counts
	// ------------------------------------------------------------------
	// the count seen in the sync cycle itself is kept as the frozen value
	// leaving receive mid-search freezes the fields as well, so the last searched count stays readable
	wire       qual_refresh = searching & ~rx_leave_i;
	wire [3:0] preamble_qual_count;
	wire [3:0] syncword_qual_count;

	dsr_qual_hold #(
		.RAW_W   (RAW_W),
		.SHIFT   (dsr_pkg::PRE_QUAL_SHIFT),
		.RST_VAL (dsr_pkg::RST_QUAL_FIELD)
	) u_preamble_qual (
		.mclk_i      (mclk_i),
		.sys_rst_i   (sys_rst_i),
		.refresh_i   (qual_refresh),
		.raw_count_i (preamble_qual_raw_i),
		.field_o     (preamble_qual_count)
	);

	dsr_qual_hold #(
		.RAW_W   (RAW_W),
		.SHIFT   (dsr_pkg::SYNC_QUAL_SHIFT),
		.RST_VAL (dsr_pkg::RST_QUAL_FIELD)
	) u_sync_qual (
		.mclk_i      (mclk_i),
		.sys_rst_i   (sys_rst_i),
		.refresh_i   (qual_refresh),
		.raw_count_i (sync_qual_raw_i),
		.field_o     (syncword_qual_count)
	);

	// ------------------------------------------------------------------
	// signal level step detection
	// ------------------------------------------------------------------
	logic [7:0] rssi_ref_q;
	logic       rssi_ref_ok_q;
	wire  [8:0] rssi_diff   = 9'($signed(rssi_db_i)) - 9'($signed(rssi_ref_q));
	wire  [8:0] rssi_mag    = rssi_diff[8] ? (9'h000 - rssi_diff) : rssi_diff;
	wire  [8:0] step_thr    = level_jump_threshold_i ? dsr_pkg::STEP_LARGE_DB : dsr_pkg::STEP_SMALL_DB;
	wire        level_step  = in_packet & rssi_ref_ok_q & rssi_valid_i & (rssi_mag >= step_thr);

	// the reference level is the one present when sync is declared
	// without a valid level at sync there is no reference, and the jump flag cannot set in that packet
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rssi_ref_q    <= 8'h00;
			rssi_ref_ok_q <= 1'b0;
		end else if (sync_hit) begin
			rssi_ref_q    <= rssi_db_i;
			rssi_ref_ok_q <= rssi_valid_i;
		end else if (rx_enter_i) begin
			rssi_ref_ok_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// sticky packet flags: jump and second sync, cleared on receive entry
	// ------------------------------------------------------------------
	wire        second_sync = in_packet & sync_detect_i & collision_watch_enable_i;
	wire [1:0]  flag_set    = {level_step, second_sync};
	wire  [1:0] flag_w;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_flag
			logic flag_bit_q;
			// a set in the same cycle as a fresh receive entry wins, so no event is lost
			wire  flag_bit_d = flag_set[gi] ? 1'b1 : (rx_enter_i ? 1'b0 : flag_bit_q);
			always_ff @(posedge mclk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					flag_bit_q <= 1'b0;
				end else begin
					flag_bit_q <= flag_bit_d;
				end
			end
			assign flag_w[gi] = flag_bit_q;
		end
	endgenerate

	wire signal_level_jump_flag = flag_w[1];
	wire second_sync_flag       = flag_w[0];

	// ------------------------------------------------------------------
	// dual sync selection, symbol rate, image, carrier offset, gain
	// ------------------------------------------------------------------
	logic        dual_sync_select_q;
	logic [3:0]  sro_q;
	logic        mirror_q;
	logic [15:0] cfo_q;
	logic [6:0]  gain_q;

	// a sync declared outside dual sync mode loads zero instead of a word choice; the bit then holds until the next sync
	wire dual_mode  = (sync_word_mode_i == dsr_pkg::SYNC_MODE_DUAL);
	wire dual_sel_d = sync_hit ? (dual_mode & upper_sync_match_i) : dual_sync_select_q;

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dual_sync_select_q <= dsr_pkg::RST_FLAGS[dsr_pkg::DF_DUAL_SYNC];
			sro_q              <= dsr_pkg::RST_FLAGS[dsr_pkg::DF_SRO_LSB +: dsr_pkg::SRO_W];
			mirror_q           <= dsr_pkg::RST_FLAGS[dsr_pkg::DF_MIRROR];
			cfo_q              <= dsr_pkg::RST_CFO;
			gain_q             <= dsr_pkg::RST_GAIN;
		end else begin
			dual_sync_select_q <= dual_sel_d;
			mirror_q           <= image_detect_i;
			gain_q             <= applied_frontend_gain_i;
			if (sro_valid_i) begin
				sro_q <= symbol_rate_offset_ind_i;
			end
			// both bytes move in the same cycle, but an update between a high read and a low read mixes two estimates
			if (cfo_valid_i) begin
				cfo_q <= carrier_offset_estimate_i;
			end
		end
	end

	// ------------------------------------------------------------------
	// register images
	// ------------------------------------------------------------------
	wire [7:0] img_quality = {preamble_qual_count, syncword_qual_count};
	wire [7:0] img_flags   = {signal_level_jump_flag, second_sync_flag, dual_sync_select_q, sro_q, mirror_q};
	wire [7:0] img_cfo_hi  = cfo_q[15:8];
	wire [7:0] img_cfo_lo  = cfo_q[7:0];
	// bit 7 of the gain image is unused and always reads zero
	wire [7:0] img_gain    = {1'b0, gain_q};
	// scale of the offset indicator depends on the timing limit, so software can read it here
	wire [7:0] img_context = {collision_watch_enable_i, sync_word_mode_i, timing_offset_limit_i, in_packet, searching};

	// ------------------------------------------------------------------
	// apb slave: no wait states, data captured in the setup cycle
	// ------------------------------------------------------------------
	wire [7:0] word_addr = {paddr_i[7:2], 2'b00};
	wire       aligned   = (paddr_i[1:0] == 2'b00);
	wire       upper_ok  = (ADDR_W > 8) ? (paddr_i >> 8) == '0 : 1'b1;
	wire       setup     = psel_i & ~penable_i;

	wire hit_quality = (word_addr == dsr_pkg::OFS_PREAMBLE_SYNC_QUALITY);
	wire hit_flags   = (word_addr == dsr_pkg::OFS_DEMODULATOR_FLAGS);
	wire hit_cfo_hi  = (word_addr == dsr_pkg::OFS_CARRIER_OFFSET_HIGH);
	wire hit_cfo_lo  = (word_addr == dsr_pkg::OFS_CARRIER_OFFSET_LOW);
	wire hit_gain    = (word_addr == dsr_pkg::OFS_APPLIED_GAIN_STATUS);
	wire hit_context = (word_addr == dsr_pkg::OFS_RX_CONTEXT_STATUS);
	wire mapped      = aligned & upper_ok &
	                   (hit_quality | hit_flags | hit_cfo_hi | hit_cfo_lo | hit_gain | hit_context);

	wire [7:0] read_byte = ({8{hit_quality}} & img_quality) |
	                       ({8{hit_flags}}   & img_flags)   |
	                       ({8{hit_cfo_hi}}  & img_cfo_hi)  |
	                       ({8{hit_cfo_lo}}  & img_cfo_lo)  |
	                       ({8{hit_gain}}    & img_gain)    |
	                       ({8{hit_context}} & img_context);

	// limitation: read data is taken in the setup cycle, so a change during the access shows on the next read
	// writes to mapped words complete cleanly but store nothing; reads touch no state
	wire [31:0] prdata_d  = (setup & ~pwrite_i & mapped) ? {24'h000000, read_byte} : 32'h00000000;
	wire        pslverr_d = setup & ~mapped;
	wire        pready_d  = setup;

	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prdata_q  <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// write data and strobes are deliberately unused
	wire unused_ok = ^{pwdata_i, pstrb_i};

	assign prdata_o  = prdata_q;
	assign pready_o  = pready_q;
	assign pslverr_o = pslverr_q;

endmodule : dsr_status_bank

//--- bench/dsr_status_bank_props.sv
// assertion checker for the demodulator status readout bank
`timescale 1ns/100ps
module dsr_status_bank_props #(
	parameter int ADDR_W = 8
) (
	input  wire logic              mclk_i,
	input  wire logic              sys_rst_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [31:0]       prdata_o,
	input  wire logic              pready_o,
	input  wire logic              pslverr_o,
	input  wire logic [6:0]        applied_frontend_gain_i,
	input  wire logic              image_detect_i
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);
	wire logic setup_w;
	wire logic rd_w;
	assign setup_w = psel_i && !penable_i;
	assign rd_w    = setup_w && !pwrite_i;
	ready_after_setup_a: assert property (setup_w |=> pready_o) else $error("no ready after setup");
	ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready held");
	ready_cause_a: assert property (pready_o |-> $past(setup_w)) else $error("ready without setup");
	err_with_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
	idle_data_zero_a: assert property (!pready_o |-> prdata_o == 32'h0) else $error("data outside access");
	upper_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h0) else $error("upper data set");
	bad_addr_a: assert property (setup_w && paddr_i[1:0] != 2'h0 |=> pslverr_o) else $error("unaligned ok");
	write_ignored_a: assert property (setup_w && pwrite_i && paddr_i == dsr_pkg::OFS_APPLIED_GAIN_STATUS
		|=> !pslverr_o) else $error("write refused");
	gain_read_a: assert property (rd_w && paddr_i == dsr_pkg::OFS_APPLIED_GAIN_STATUS
		&& $stable(applied_frontend_gain_i) |=> prdata_o[7:0] == {1'b0, $past(applied_frontend_gain_i)})
		else $error("gain read wrong");
	mirror_read_a: assert property (rd_w && paddr_i == dsr_pkg::OFS_DEMODULATOR_FLAGS
		&& $stable(image_detect_i) |=> prdata_o[0] == $past(image_detect_i))
		else $error("image flag wrong");
	cover property (pready_o && pslverr_o);
	cover property (setup_w && pwrite_i);
	cover property (pready_o && prdata_o[7]);
endmodule : dsr_status_bank_props

bind dsr_status_bank dsr_status_bank_props #(.ADDR_W(ADDR_W)) u_props (
	.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.applied_frontend_gain_i(applied_frontend_gain_i), .image_detect_i(image_detect_i)
);

//--- bench/dsr_host_model.sv
// apb host model issuing single transfers to the status bank
`timescale 1ns/100ps
module dsr_host_model (
	input  wire logic        mclk_i,
	input  wire logic        pready_i,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pslverr_i,
	output logic      [7:0]  paddr_o,
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic      [31:0] pwdata_o,
	output logic      [3:0]  pstrb_o
);
	initial begin
		{paddr_o, psel_o, penable_o, pwrite_o, pwdata_o, pstrb_o} = '0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		@(posedge mclk_i);
		{paddr_o, pwrite_o, pwdata_o, pstrb_o} <= {a, w, wd, 4'hf};
		psel_o <= 1'b1;
		@(posedge mclk_i);
		penable_o <= 1'b1;
		// no cycle count is assumed: only the bench watchdog ends a wait on a dead slave
		do begin
			@(posedge mclk_i);
		end while (pready_i !== 1'b1);
		rd = prdata_i;
		er = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
	endtask : xfer
endmodule : dsr_host_model

//--- bench/dsr_status_bank_test.sv
// self-checking testbench for the demodulator status readout bank
`timescale 1ns/100ps
module dsr_status_bank_test;
	logic        mclk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, rssi_v, thr, coll, upper, image;
	logic [7:0]  paddr, pre_raw, sync_raw, rssi;
	logic [31:0] pwdata, prdata, msk, d;
	logic [5:0]  pl;
	logic [1:0]  tol;
	logic [3:0]  pstrb, sro;
	logic [2:0]  mode;
	logic [15:0] cfo;
	logic [6:0]  gain;
	logic        er;
	int          fails, n_tests;
	dsr_host_model u_host (.mclk_i(mclk_i), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr),
		.paddr_o(paddr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .pwdata_o(pwdata), .pstrb_o(pstrb));
	dsr_status_bank u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .rx_enter_i(pl[0]), .rx_leave_i(pl[5]), .sync_found_i(pl[1]),
		.preamble_qual_raw_i(pre_raw), .sync_qual_raw_i(sync_raw), .rssi_db_i(rssi), .rssi_valid_i(rssi_v),
		.level_jump_threshold_i(thr), .sync_detect_i(pl[2]), .collision_watch_enable_i(coll),
		.sync_word_mode_i(mode), .upper_sync_match_i(upper), .symbol_rate_offset_ind_i(sro),
		.sro_valid_i(pl[3]), .timing_offset_limit_i(tol), .carrier_offset_estimate_i(cfo),
		.cfo_valid_i(pl[4]), .applied_frontend_gain_i(gain), .image_detect_i(image));
	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
		u_host.xfer(1'b0, a, 32'h0, d, er);
		chk($sformatf("data at %h", a), d & msk, e);
		chk($sformatf("error at %h", a), {31'h0, er}, {31'h0, ee});
	endtask : rd
	task automatic pulse(input int b);
		@(posedge mclk_i);
		pl[b] <= 1'b1;
		@(posedge mclk_i);
		pl <= 6'h0;
	endtask : pulse
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		#20000;
		fails++;
		stop_test();
	end
	initial begin
		{pl, pre_raw, sync_raw, rssi, rssi_v, thr, coll, mode, upper, sro, cfo, gain, image, tol} = '0;
		msk = 32'hffffffff;
		sys_rst_i = 1'b1;
		repeat (2) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		rd(dsr_pkg::OFS_PREAMBLE_SYNC_QUALITY, 32'hff, 1'b0);
		rd(dsr_pkg::OFS_DEMODULATOR_FLAGS, 32'h00, 1'b0);
		rd(dsr_pkg::OFS_CARRIER_OFFSET_HIGH, 32'h00, 1'b0);
		rd(dsr_pkg::OFS_CARRIER_OFFSET_LOW, 32'h00, 1'b0);
		rd(dsr_pkg::OFS_APPLIED_GAIN_STATUS, 32'h00, 1'b0);
		$display("test reset values done");
		// 19 aliases to 3, 37 halves to 18 and aliases to 2
		{pre_raw, sync_raw, mode, upper, rssi, rssi_v, coll, image} <= {8'h13, 8'h25, 3'h7, 1'b1, 8'h0a, 3'h7};
		pulse(0);
		rd(dsr_pkg::OFS_PREAMBLE_SYNC_QUALITY, 32'h32, 1'b0);
		{pre_raw, sync_raw} <= {8'h27, 8'h1e};
		rd(dsr_pkg::OFS_PREAMBLE_SYNC_QUALITY, 32'h7f, 1'b0);
		pulse(1);
		{pre_raw, sync_raw} <= 16'h0000;
		rd(dsr_pkg::OFS_PREAMBLE_SYNC_QUALITY, 32'h7f, 1'b0);
		rd(dsr_pkg::OFS_DEMODULATOR_FLAGS, 32'h21, 1'b0);
		{rssi, sro} <= {8'h0e, 4'hb};
		pulse(2);
		pulse(3);
		rd(dsr_pkg::OFS_DEMODULATOR_FLAGS, 32'hf7, 1'b0);
		rd(dsr_pkg::OFS_DEMODULATOR_FLAGS, 32'hf7, 1'b0);
		$display("test search and packet done");
		{thr, coll, mode, rssi, image} <= {1'b1, 1'b0, 3'h3, 8'h0a, 1'b0};
		pulse(0);
		rd(dsr_pkg::OFS_PREAMBLE_SYNC_QUALITY, 32'h00, 1'b0);
		pulse(1);
		rssi <= 8'h0e;
		pulse(2);
		msk = 32'he1;
		rd(dsr_pkg::OFS_DEMODULATOR_FLAGS, 32'h00, 1'b0);
		rssi <= 8'h11;
		repeat (2) @(posedge mclk_i);
		rd(dsr_pkg::OFS_DEMODULATOR_FLAGS, 32'h80, 1'b0);
		msk = 32'hffffffff;
		$display("test threshold and watch off done");
		rd(dsr_pkg::OFS_RX_CONTEXT_STATUS, 32'h32, 1'b0);
		{pre_raw, sync_raw, tol, rssi} <= {8'h05, 8'h0a, 2'h3, 8'h0a};
		pulse(0);
		pulse(5);
		{pre_raw, sync_raw} <= 16'h0000;
		rd(dsr_pkg::OFS_PREAMBLE_SYNC_QUALITY, 32'h55, 1'b0);
		rd(dsr_pkg::OFS_RX_CONTEXT_STATUS, 32'h3c, 1'b0);
		msk = 32'he1;
		rd(dsr_pkg::OFS_DEMODULATOR_FLAGS, 32'h00, 1'b0);
		msk = 32'hffffffff;
		$display("test leave and context done");
		{cfo, gain} <= {16'h8a3c, 7'h55};
		pulse(4);
		rd(dsr_pkg::OFS_CARRIER_OFFSET_HIGH, 32'h8a, 1'b0);
		rd(dsr_pkg::OFS_CARRIER_OFFSET_LOW, 32'h3c, 1'b0);
		rd(dsr_pkg::OFS_APPLIED_GAIN_STATUS, 32'h55, 1'b0);
		u_host.xfer(1'b1, dsr_pkg::OFS_APPLIED_GAIN_STATUS, 32'hffffffff, d, er);
		chk("write error", {31'h0, er}, 32'h0);
		u_host.xfer(1'b1, dsr_pkg::OFS_CARRIER_OFFSET_HIGH, 32'h00000000, d, er);
		rd(dsr_pkg::OFS_APPLIED_GAIN_STATUS, 32'h55, 1'b0);
		rd(dsr_pkg::OFS_CARRIER_OFFSET_HIGH, 32'h8a, 1'b0);
		msk = 32'h0;
		rd(8'h18, 32'h0, 1'b1);
		rd(8'h02, 32'h0, 1'b1);
		$display("test offset gain and writes done");
		stop_test();
	end
endmodule : dsr_status_bank_test
